// [design/ccpct_core.sv]
`timescale 1ns/10ps
module ccpct_core
  import ccpct_pkg::*;
(
  // APB slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Timer inputs
  input  wire logic [15:0]        sixteen_bit_timer,
  input  wire logic [7:0]         tmr_a_count,
  input  wire logic [1:0]         tmr_a_fine,
  input  wire logic               tmr_a_period_evt,
  input  wire logic [7:0]         tmr_b_count,
  input  wire logic [1:0]         tmr_b_fine,
  input  wire logic               tmr_b_period_evt,
  input  wire logic [7:0]         tmr_c_count,
  input  wire logic [1:0]         tmr_c_fine,
  input  wire logic               tmr_c_period_evt,
  // Capture sources
  input  wire logic               capture_pin,
  input  wire logic               comparator1_synced,
  input  wire logic               comparator2_synced,
  input  wire logic               pin_change_event,
  input  wire logic [3:0]         logic_cell_outputs,
  // Pin side
  output logic                    pin_out,
  output logic                    pin_oe,
  output logic                    pin_select_out,
  // Internal PWM consumers
  output logic                    waveform_generator_in,
  output logic                    adc_trigger,
  output logic                    timer_reset_src,
  output logic                    measurement_window,
  output logic                    logic_cell_in,
  // Events and selects for other units
  output logic                    unit_flag_set,
  output logic                    timer_clear_req,
  output ccpct_pkg::ccpct_tsel_t  pwm_ch4_timer_sel,
  output ccpct_pkg::ccpct_tsel_t  pwm_ch3_timer_sel,
  output ccpct_pkg::ccpct_tsel_t  unit2_timer_sel
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Duty value from the byte pair by alignment
  function automatic logic [9:0] duty_of(input logic       left,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
    duty_of = left ? {hi, lo[7:6]} : {hi[1:0], lo};
  endfunction : duty_of

  // Pick one of three timers' fields by a select code
  function automatic logic [10:0] tb_pick(input ccpct_tsel_t s,
                                          input logic [10:0] a,
                                          input logic [10:0] b,
                                          input logic [10:0] c);
    if (s == 2'h0)
      tb_pick = a;
    else if (s == 2'h1)
      tb_pick = b;
    else if (s == 2'h2)
      tb_pick = c;
    else
      tb_pick = 11'h000; // Reserved code: no time base
  endfunction : tb_pick

  // ************************************************************
  // Registers and state
  // ************************************************************
  logic        enable_r;          // Unit enable
  logic        duty_alignment_r;  // Left alignment when set
  logic [3:0]  mode_r;            // Mode field
  logic [7:0]  tb_select_r;       // Time base selection
  logic [7:0]  value_low_r;       // Value low byte
  logic [7:0]  value_high_r;      // Value high byte
  logic [2:0]  cap_select_r;      // Capture source
  logic        out_r;             // Output data value
  logic        out_nxt;           // Next output value
  logic        pulse_r;           // Compare pulse in progress
  logic        match_d_r;         // Compare match last cycle
  logic        src_d_r;           // Capture source last cycle
  logic [3:0]  presc_r;           // Capture prescale count
  logic        flag_r;            // Event pulse
  logic        tclr_r;            // Timer clear pulse
  logic        oe_r;              // Pin drive enable
  logic [31:0] prdata_r;          // Read data
  logic        pready_r;          // Access phase ready
  logic        pslverr_r;         // Unmapped address

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable && pready_r;
  wire wr_en     = access_ph && pwrite;
  wire hit_ctl   = (paddr == OFS_UNIT_CONTROL);
  wire hit_tb    = (paddr == OFS_TB_SELECT);
  wire hit_lo    = (paddr == OFS_VALUE_LOW);
  wire hit_hi    = (paddr == OFS_VALUE_HIGH);
  wire hit_cap   = (paddr == OFS_CAP_SELECT);
  wire mapped    = hit_ctl || hit_tb || hit_lo || hit_hi || hit_cap;

  // Control readback: bit 6 reads zero, bit 5 is live output
  wire [7:0] ctl_rd = {enable_r, 1'b0, out_r, duty_alignment_r, mode_r};

  // Read mux, address decode as an if chain
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_ctl)
      rd_byte = ctl_rd;
    else if (hit_tb)
      rd_byte = tb_select_r;
    else if (hit_lo)
      rd_byte = value_low_r;
    else if (hit_hi)
      rd_byte = value_high_r;
    else if (hit_cap)
      rd_byte = {5'h00, cap_select_r};
  end

  // ************************************************************
  // Mode decode
  // ************************************************************
  wire is_off  = (mode_r == MODE_OFF);
  wire is_pwm  = (mode_r[3:2] == 2'b11);
  wire is_cap  = (mode_r[3:2] == 2'b01) || (mode_r == MODE_CAP_BOTH);
  wire is_cmp  = !is_off && !is_pwm && !is_cap;
  wire active  = enable_r && !is_off;
  wire pwm_run = active && is_pwm;

  // ************************************************************
  // Time base selection for this unit
  // ************************************************************
  wire [10:0] tb_sel = tb_pick(tb_select_r[1:0],
                               {tmr_a_period_evt, tmr_a_count, tmr_a_fine},
                               {tmr_b_period_evt, tmr_b_count, tmr_b_fine},
                               {tmr_c_period_evt, tmr_c_count, tmr_c_fine});
  // Ten-bit base counts system clock derived ticks
  wire [9:0]  timebase   = tb_sel[9:0];
  wire        period_evt = tb_sel[10];
  wire [9:0]  duty       = duty_of(duty_alignment_r, value_high_r, value_low_r);

  // ************************************************************
  // Capture source selection and edge qualification
  // ************************************************************
  logic pin_level;                      // Filtered own pin

  ccpct_sync3 u_sync
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_raw   (capture_pin),
    .pin_level (pin_level)
  );

  logic cap_src;
  always_comb
  begin
    cap_src = pin_level;
    if (cap_select_r == 3'h1)
      cap_src = comparator1_synced;
    else if (cap_select_r == 3'h2)
      cap_src = comparator2_synced;
    else if (cap_select_r == 3'h3)
      cap_src = pin_change_event;
    else if (cap_select_r[2])
      cap_src = logic_cell_outputs[cap_select_r[1:0]];
  end

  wire rise = cap_src && !src_d_r;
  wire fall = !cap_src && src_d_r;
  wire need4  = (mode_r == MODE_CAP_RISE4);
  wire need16 = (mode_r == MODE_CAP_RISE16);
  wire [3:0] presc_last = need16 ? PRESC_LAST16 : PRESC_LAST4;

  // Qualified capture event per mode
  logic cap_evt;
  always_comb
  begin
    cap_evt = 1'b0;
    if (!active || !is_cap)
      cap_evt = 1'b0;
    else if (mode_r == MODE_CAP_BOTH)
      cap_evt = rise || fall;
    else if (mode_r == MODE_CAP_FALL)
      cap_evt = fall;
    else if (mode_r == MODE_CAP_RISE)
      cap_evt = rise;
    else
      cap_evt = rise && (presc_r == presc_last);
  end

  // ************************************************************
  // Compare match detection
  // ************************************************************
  wire match_now = (sixteen_bit_timer == {value_high_r, value_low_r});
  wire cmp_evt   = active && is_cmp && match_now && !match_d_r;

  // ************************************************************
  // PWM event generator
  // ************************************************************
  logic pwm_set;
  logic pwm_clr;

  ccpct_pwm u_pwm
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (pwm_run),
    .period_evt (period_evt),
    .timebase   (timebase),
    .duty       (duty),
    .pwm_set    (pwm_set),
    .pwm_clr    (pwm_clr)
  );

  // ************************************************************
  // Next output value
  // ************************************************************
  always_comb
  begin
    out_nxt = out_r;
    if (!active)
      out_nxt = 1'b0;
    else if (is_pwm)
    begin
      if (pwm_set)
        out_nxt = 1'b1;
      else if (pwm_clr)
        out_nxt = 1'b0;
    end
    else if (pulse_r)
      out_nxt = 1'b0; // Pulse lasts one cycle
    else if (cmp_evt)
    begin
      case (mode_r)
        MODE_CMP_SET:   out_nxt = 1'b1;
        MODE_CMP_CLR:   out_nxt = 1'b0;
        MODE_CMP_PULSE: out_nxt = 1'b1;
        MODE_PULSE_CLR: out_nxt = 1'b1;
        default:        out_nxt = !out_r;
      endcase
    end
  end

  wire pulse_mode = (mode_r == MODE_CMP_PULSE) || (mode_r == MODE_PULSE_CLR);
  wire clr_mode   = (mode_r == MODE_PULSE_CLR) || (mode_r == MODE_TOG_CLR);

  // ************************************************************
  // Unit state: output, pulse, edge history, prescaler
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_r     <= 1'b0;
      pulse_r   <= 1'b0;
      match_d_r <= 1'b0;
      src_d_r   <= 1'b0;
      presc_r   <= 4'h0;
      flag_r    <= 1'b0;
      tclr_r    <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      out_r     <= out_nxt;
      pulse_r   <= cmp_evt && pulse_mode;
      match_d_r <= match_now;
      src_d_r   <= cap_src;
      flag_r    <= cap_evt || cmp_evt;
      tclr_r    <= cmp_evt && clr_mode;
      oe_r      <= active && !is_cap;
      if (!active || !(need4 || need16))
        presc_r <= 4'h0;
      else if (rise)
        presc_r <= (presc_r == presc_last) ? 4'h0 : presc_r + 4'h1;
    end
  end

  // ************************************************************
  // Software registers, capture load
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r         <= RST_UNIT_CONTROL[BIT_ENABLE];
      duty_alignment_r <= RST_UNIT_CONTROL[BIT_ALIGN];
      mode_r           <= RST_UNIT_CONTROL[3:0];
      tb_select_r      <= RST_TB_SELECT;
      value_low_r      <= RST_VALUE_BYTE;
      value_high_r     <= RST_VALUE_BYTE;
      cap_select_r     <= RST_CAP_SELECT;
    end
    else
    begin
      if (wr_en && hit_ctl)
      begin
        enable_r         <= pwdata[BIT_ENABLE];
        duty_alignment_r <= pwdata[BIT_ALIGN];
        mode_r           <= pwdata[3:0];
      end
      if (wr_en && hit_tb)
        tb_select_r <= pwdata[7:0];
      if (wr_en && hit_cap)
        cap_select_r <= pwdata[2:0];
      if (cap_evt)
      begin
        value_low_r  <= sixteen_bit_timer[7:0];
        value_high_r <= sixteen_bit_timer[15:8];
      end
      else
      begin
        if (wr_en && hit_lo)
          value_low_r <= pwdata[7:0];
        if (wr_en && hit_hi)
          value_high_r <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // APB answer: one setup, one access cycle
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !mapped;
      if (setup_ph && !pwrite)
        prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata                = prdata_r;
  assign pready                = pready_r;
  assign pslverr               = pslverr_r;
  assign pin_out               = out_r;
  assign pin_oe                = oe_r;
  assign pin_select_out        = out_r;
  assign waveform_generator_in = out_r;
  assign adc_trigger           = out_r;
  assign timer_reset_src       = out_r;
  assign measurement_window    = out_r;
  assign logic_cell_in         = out_r;
  assign unit_flag_set         = flag_r;
  assign timer_clear_req       = tclr_r;
  assign pwm_ch4_timer_sel     = tb_select_r[7:6];
  assign pwm_ch3_timer_sel     = tb_select_r[5:4];
  assign unit2_timer_sel       = tb_select_r[3:2];

endmodule : ccpct_core

// [design/ccpct_pkg.sv]
// ************************************************************
// Shared constants of the capture/compare/PWM control block
// ************************************************************
package ccpct_pkg;

  // ************************************************************
  // Register byte offsets on the APB
  // ************************************************************
  localparam logic [7:0] OFS_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_TB_SELECT    = 8'h04;
  localparam logic [7:0] OFS_VALUE_LOW    = 8'h08;
  localparam logic [7:0] OFS_VALUE_HIGH   = 8'h0c;
  localparam logic [7:0] OFS_CAP_SELECT   = 8'h10;

  // ************************************************************
  // Control field positions
  // ************************************************************
  localparam int BIT_ENABLE    = 7;
  localparam int BIT_OUT_VALUE = 5;
  localparam int BIT_ALIGN     = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_UNIT_CONTROL = 8'h00;
  localparam logic [7:0] RST_TB_SELECT    = 8'h00;
  localparam logic [7:0] RST_VALUE_BYTE   = 8'h00;
  localparam logic [2:0] RST_CAP_SELECT   = 3'h0;

  // ************************************************************
  // Mode encodings
  // ************************************************************
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR    = 4'h1;
  localparam logic [3:0] MODE_TOGGLE     = 4'h2;
  localparam logic [3:0] MODE_CAP_BOTH   = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET    = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR    = 4'h9;
  localparam logic [3:0] MODE_CMP_PULSE  = 4'ha;
  localparam logic [3:0] MODE_PULSE_CLR  = 4'hb;

  // Capture prescale terminal counts
  localparam logic [3:0] PRESC_LAST4  = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  // Which of three 8-bit timers drives a PWM time base
  typedef logic [1:0] ccpct_tsel_t;

endpackage : ccpct_pkg

// [design/ccpct_pwm.sv]
`timescale 1ns/10ps
// ************************************************************
// PWM duty latch and set/clear event generator
// ************************************************************
module ccpct_pwm
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       period_evt,
  input  wire logic [9:0] timebase,
  input  wire logic [9:0] duty,
  // Events to the output flop
  output logic            pwm_set,
  output logic            pwm_clr
);

  logic [9:0] latch_r;   // Double-buffered duty value

  // Latch duty at period roll-over; cleared when stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_r <= 10'h000;
    else if (!run)
      latch_r <= 10'h000;
    else if (period_evt)
      latch_r <= duty;
  end

  // Set at period start unless new duty is zero
  assign pwm_set = run && period_evt && (duty != 10'h000);
  // Clear when time base meets the latched duty
  assign pwm_clr = run && !period_evt && (timebase == latch_r);

endmodule : ccpct_pwm

// [design/ccpct_sync3.sv]
`timescale 1ns/10ps
// ************************************************************
// Three-stage pin synchroniser with agreement filter
// ************************************************************
module ccpct_sync3
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw pin and filtered level
  input  wire logic pin_raw,
  output logic      pin_level
);

  logic s1_r;    // First stage, read only by s2
  logic s2_r;    // Second stage
  logic s3_r;    // Third stage
  logic lvl_r;   // Accepted level

  // Shift chain; level changes only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
    end
  end

  assign pin_level = lvl_r;

endmodule : ccpct_sync3

// [test/ccpct_core_props.sv]
`timescale 1ns/10ps
// ************************************************************
// Port checker of the control block
// ************************************************************
module ccpct_core_props
  import ccpct_pkg::*;
(
  // Clock, reset and APB
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Pin and its internal copies
  input wire logic                   pin_out,
  input wire logic                   pin_oe,
  input wire logic                   pin_select_out,
  input wire logic                   waveform_generator_in,
  input wire logic                   adc_trigger,
  input wire logic                   timer_reset_src,
  input wire logic                   measurement_window,
  input wire logic                   logic_cell_in,
  // Events and time base selects
  input wire logic                   unit_flag_set,
  input wire logic                   timer_clear_req,
  input wire ccpct_pkg::ccpct_tsel_t pwm_ch4_timer_sel,
  input wire ccpct_pkg::ccpct_tsel_t pwm_ch3_timer_sel,
  input wire ccpct_pkg::ccpct_tsel_t unit2_timer_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Request decode
  wire       setup = psel && !penable;
  wire       hit   = paddr inside {OFS_UNIT_CONTROL, OFS_TB_SELECT, OFS_VALUE_LOW, OFS_VALUE_HIGH, OFS_CAP_SELECT};
  wire       wdone = psel && penable && pready && pwrite;
  wire [5:0] tsel  = pwdata[7:2];
  // Answer lasts exactly one cycle
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer;
    setup |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("APB answer not one cycle");
  property p_refuse;
    setup && !hit |=> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_refuse: assert property (p_refuse) else $error("Unmapped access not refused");
  property p_ctrl_read;
    setup && !pwrite && paddr == OFS_UNIT_CONTROL |=> prdata[6] == 1'b0 && prdata[5] == $past(pin_out);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("Control read wrong");
  property p_cap_read;
    setup && !pwrite && paddr == OFS_CAP_SELECT |=> prdata[31:3] == 29'h0;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("Capture select upper bits set");
  property p_copies;
    pin_select_out == pin_out && waveform_generator_in == pin_out && adc_trigger == pin_out
      && timer_reset_src == pin_out && measurement_window == pin_out && logic_cell_in == pin_out;
  endproperty
  a_copies: assert property (p_copies) else $error("Output copies differ");
  property p_tsel;
    wdone && paddr == OFS_TB_SELECT |=> {pwm_ch4_timer_sel, pwm_ch3_timer_sel, unit2_timer_sel} == $past(tsel);
  endproperty
  a_tsel: assert property (p_tsel) else $error("Time base selects wrong");
  property p_clr_flag;
    timer_clear_req |-> unit_flag_set;
  endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("Timer clear without flag");
  property p_off;
    wdone && paddr == OFS_UNIT_CONTROL && pwdata[3:0] == MODE_OFF |-> ##2 !pin_out && !pin_oe;
  endproperty
  a_off: assert property (p_off) else $error("Mode off leaves pin active");
  property p_reset;
    $rose(presetn) |-> !pin_oe && !pin_out;
  endproperty
  a_reset: assert property (p_reset) else $error("Pin active after reset");
  property p_flag_one;
    unit_flag_set |=> !unit_flag_set;
  endproperty
  a_flag_one: assert property (p_flag_one) else $error("Flag longer than one cycle");
endmodule : ccpct_core_props

bind ccpct_core ccpct_core_props i_ccpct_core_props (.*);

// [test/ccpct_core_tb_top.sv]
`timescale 1ns/10ps
// ************************************************************
// Bench of the control block
// ************************************************************
module ccpct_core_tb_top;
  import ccpct_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, src = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, hi;
  logic        pready, pslverr, err, hold = 1'b0, pevt, pin_out, pin_oe, flag, tclr;
  logic [15:0] timer16, v;
  logic [7:0]  count;
  logic [1:0]  fine;
  ccpct_tsel_t sel4, sel3, sel2;
  int          fail_count = 0, n_tests = 0, cycles = 0, flag_cnt = 0, clr_cnt = 0, base, cbase;
  logic [7:0]  ofs [5] = '{OFS_UNIT_CONTROL, OFS_TB_SELECT, OFS_VALUE_LOW, OFS_VALUE_HIGH, OFS_CAP_SELECT};
  logic [15:0] rw [5] = '{16'h0000, 16'he4e4, 16'ha5a5, 16'h5a5a, 16'hff07};
  logic [3:0]  cmode [5] = '{MODE_CAP_BOTH, MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
  int          cexp [5] = '{32, 16, 16, 4, 1};
  logic [11:0] cmp [7] = '{12'h88e, 12'h89a, 12'h82e, 12'h81b, 12'h8bb, 12'h8aa, 12'h080};
  logic [24:0] pw [4] = '{25'h118_fc09, 25'h13b_0100, 25'h11c_0000, 25'h13f_023f};
  always #50 pclk = ~pclk;
  ccpct_far_model #(.PERIOD(8'h03)) i_ccpct_far_model (.pclk(pclk), .presetn(presetn), .hold(hold),
    .clear_req(tclr), .timer16(timer16), .count(count), .fine(fine), .period_evt(pevt));
  ccpct_core i_ccpct_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sixteen_bit_timer(timer16), .tmr_a_count(count), .tmr_a_fine(fine), .tmr_a_period_evt(pevt),
    .tmr_b_count(count), .tmr_b_fine(fine), .tmr_b_period_evt(pevt), .tmr_c_count(count),
    .tmr_c_fine(fine), .tmr_c_period_evt(pevt), .capture_pin(src[0]), .comparator1_synced(src[1]),
    .comparator2_synced(src[2]), .pin_change_event(src[3]), .logic_cell_outputs(src[7:4]),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_select_out(), .waveform_generator_in(), .adc_trigger(),
    .timer_reset_src(), .measurement_window(), .logic_cell_in(), .unit_flag_set(flag),
    .timer_clear_req(tclr), .pwm_ch4_timer_sel(sel4), .pwm_ch3_timer_sel(sel3), .unit2_timer_sel(sel2));
  // Event counters and watchdog
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (flag === 1'b1)
      flag_cnt <= flag_cnt + 1;
    if (tclr === 1'b1)
      clr_cnt <= clr_cnt + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  // One APB transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, {24'h0, d}, r);
  endtask : wr
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_tb(input logic [9:0] t);
    int n;
    for (n = 0; n < 64 && {count, fine} !== t; n++)
      @(posedge pclk);
  endtask : wait_tb
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0, q);
      check("reset value", q, 32'h0);
      if (i > 0)
      begin
        wr(ofs[i], rw[i][15:8]);
        apb(1'b0, ofs[i], 32'h0, q);
        check("readback", q, {24'h0, rw[i][7:0]});
      end
    end
    check("time base selects", {sel4, sel3, sel2}, 32'h39);
    apb(1'b0, 8'h14, 32'h0, q);
    check("unmapped error", err, 32'h1);
    wr(OFS_CAP_SELECT, 8'h00);
    foreach (cmode[i])
    begin
      wr(OFS_UNIT_CONTROL, {4'h8, cmode[i]});
      base = flag_cnt;
      repeat (16)
      begin
        src[0] <= 1'b1;
        repeat (4) @(posedge pclk);
        src[0] <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      check("capture events", flag_cnt - base, cexp[i]);
      wr(OFS_UNIT_CONTROL, 8'h00);
    end
    for (int s = 0; s < 8; s++)
    begin
      hold <= 1'b0;
      wr(OFS_CAP_SELECT, 8'(s));
      wr(OFS_UNIT_CONTROL, {4'h8, MODE_CAP_RISE});
      base = flag_cnt;
      hold <= 1'b1;
      src <= 8'h01 << s;
      repeat (8) @(posedge pclk);
      src <= 8'h00;
      apb(1'b0, OFS_VALUE_LOW, 32'h0, q);
      apb(1'b0, OFS_VALUE_HIGH, 32'h0, hi);
      check("captured value", {hi[7:0], q[7:0]}, {16'h0, timer16});
      check("capture flag", flag_cnt - base, 32'h1);
      wr(OFS_UNIT_CONTROL, 8'h00);
    end
    hold <= 1'b0;
    foreach (cmp[i])
    begin
      v = timer16 + 16'h0040;
      wr(OFS_VALUE_LOW, v[7:0]);
      wr(OFS_VALUE_HIGH, v[15:8]);
      base = flag_cnt;
      cbase = clr_cnt;
      wr(OFS_UNIT_CONTROL, cmp[i][11:4]);
      repeat (100) @(posedge pclk);
      check("compare pin", {pin_oe, pin_out}, {30'h0, cmp[i][3:2]});
      check("compare flag", flag_cnt - base, {31'h0, cmp[i][1]});
      check("timer clear", clr_cnt - cbase, {31'h0, cmp[i][0]});
      apb(1'b0, OFS_UNIT_CONTROL, 32'h0, q);
      check("output bit", q, {24'h0, cmp[i][11:10], cmp[i][2], cmp[i][8:4]});
    end
    foreach (pw[i])
    begin
      wr(OFS_VALUE_HIGH, pw[i][15:8]);
      wr(OFS_VALUE_LOW, pw[i][7:0]);
      wr(OFS_UNIT_CONTROL, pw[i][24:17] | 8'h80);
      repeat (40) @(posedge pclk);
      wait_tb(10'h005);
      check("pwm high", pin_out, {31'h0, pw[i][0]});
      wait_tb(10'h00d);
      check("pwm low", pin_out, 32'h0);
    end
    test_done();
  end
endmodule : ccpct_core_tb_top

// [test/ccpct_far_model.sv]
`timescale 1ns/10ps
// ************************************************************
// Timers at the far side of the block
// ************************************************************
module ccpct_far_model
#(
  parameter logic [7:0] PERIOD = 8'h03  // Short period keeps runs brief
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Freeze and clear requests
  input  wire logic        hold,
  input  wire logic        clear_req,
  // Timer values
  output logic [15:0]      timer16,
  output logic [7:0]       count,
  output logic [1:0]       fine,
  output logic             period_evt
);
  // Timers step on the system clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer16       <= 16'h0000;
      {count, fine} <= 10'h000;
      period_evt    <= 1'b0;
    end
    else
    begin
      if (clear_req)
        timer16 <= 16'h0000;
      else if (!hold)
        timer16 <= timer16 + 16'h0001;
      period_evt    <= count == PERIOD && fine == 2'h3;
      {count, fine} <= (count == PERIOD && fine == 2'h3) ? 10'h000 : {count, fine} + 10'h001;
    end
  end
endmodule : ccpct_far_model
